// File: design/cbl_cfg.svh
//
// Summary of operation
// - Pin disable bit 3 set forces the multi-function pin low internally.
// - Bits 5:4 pick pin role: invert, external clamp, hold, pixel clock.
// - Clamp pulse starts restore if enabled, averaging if enabled, always loads offsets.
// - Internal clamp mode generates the clamp pulse every line by itself.
// - External clamp mode loads offsets only at that pulse's leading edge.
// - Without internal clamp, gain loads may wait up to 100 ms; offsets load only at a clamp pulse.
// - Bit 6 set halves the crystal clock output; clear passes crystal rate.
// - Bit 7 set holds the crystal clock output low; clear lets it toggle.
// - Thirteen-bit start pixel after sync trailing edge begins restore and averaging.
// - Clamp width sets restore pulse pixels; width 0 or 1 makes no pulse.
// - Clamp width affects only the restore pulse, never the averaging window.
// - Config bit 0 clear enables black-level compensation; set disables it.
// - Bits 3:2 pick averaged pixels per line: 16, 32, 64, 128.
// - Bits 6:4 set time constant as two to the power five plus field.
// - Bus width bit 0 clear drives secondary buses low; set outputs 48 bits.
`ifndef CBL_CFG_SVH
`define CBL_CFG_SVH
`define CBL_ADDR_PIN_CTRL   8'h13
`define CBL_ADDR_START_HI   8'h14
`define CBL_ADDR_START_LO   8'h15
`define CBL_ADDR_WIDTH      8'h16
`define CBL_ADDR_BLC        8'h17
`define CBL_ADDR_OUTFMT     8'h18
`define CBL_RST_PIN_CTRL    8'h00
`define CBL_RST_START_HI    8'h00
`define CBL_RST_START_LO    8'h00
`define CBL_RST_WIDTH       8'h10
`define CBL_RST_BLC         8'h40
`define CBL_RST_OUTFMT      8'h00
`define CBL_MIN_WIDTH       8'h02
`define CBL_BIT_PIN_DIS     3
`define CBL_BIT_XTAL_HALF   6
`define CBL_BIT_XTAL_OFF    7
`define CBL_BIT_BLC_DIS     0
`define CBL_BIT_BUS48       0
`define CBL_PX_BASE         5
`define CBL_TC_BASE         5
`define CBL_HOLD_MS         100
`define CBL_CLK_KHZ         25000
`define CBL_HOLD_CYC        (`CBL_HOLD_MS * `CBL_CLK_KHZ)
`endif

// File: design/cbl_pkg.sv
package cbl_pkg;
  typedef enum logic [1:0] {
    CBL_PIN_INVERT,
    CBL_PIN_EXT_CLAMP,
    CBL_PIN_EXT_HOLD,
    CBL_PIN_EXT_EXTERNAL_PIXEL_CLOCK
  } cbl_pin_fn_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } cbl_pixel_t;

  typedef struct packed {
    logic        restore;
    logic        average_start;
    logic        offset_load;
    logic        gain_load;
  } cbl_clamp_evt_t;
endpackage : cbl_pkg

// File: design/cbl_top.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "cbl_cfg.svh"
module cbl_top #(
  parameter int unsigned HOLD_CYC = `CBL_HOLD_CYC
) (
  input  wire logic               core_clk_i,
  input  wire logic               rstn_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic [7:0]              rdata_o,
  input  wire logic               multi_pin_i,
  input  wire logic               hsync_i,
  input  wire logic               crystal_clk_i,
  input  wire logic               restore_en_i,
  input  wire cbl_pkg::cbl_pixel_t pix_primary_i,
  input  wire cbl_pkg::cbl_pixel_t pix_secondary_i,
  output logic                    sample_clock_invert_o,
  output logic                    ext_hold_o,
  output logic                    external_pixel_clock_o,
  output logic                    crystal_clock_output_o,
  output cbl_pkg::cbl_clamp_evt_t clamp_evt_o,
  output logic                    restore_pulse_o,
  output logic                    average_window_o,
  output logic                    auto_black_level_comp_en_o,
  output logic [7:0]              average_pixels_o,
  output logic [12:0]             time_constant_lines_o,
  output cbl_pkg::cbl_pixel_t     primary_bus_o,
  output cbl_pkg::cbl_pixel_t     secondary_bus_o
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0]          pin_ctrl;
  logic [7:0]          start_hi;
  logic [7:0]          start_lo;
  logic [7:0]          width;
  logic [7:0]          blc_cfg;
  logic [7:0]          outfmt;
  logic                gain_pending;
  logic [12:0]         start_px;
  cbl_pkg::cbl_pin_fn_t pin_fn;

  assign start_px = {start_hi[4:0], start_lo};
  assign pin_fn   = cbl_pkg::cbl_pin_fn_t'(pin_ctrl[5:4]);

  // Register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      `CBL_ADDR_PIN_CTRL: reg_read = pin_ctrl;
      `CBL_ADDR_START_HI: reg_read = {3'h0, start_hi[4:0]};
      `CBL_ADDR_START_LO: reg_read = start_lo;
      `CBL_ADDR_WIDTH:    reg_read = width;
      `CBL_ADDR_BLC:      reg_read = blc_cfg;
      `CBL_ADDR_OUTFMT:   reg_read = outfmt;
      default:            reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Register writes
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_ctrl <= `CBL_RST_PIN_CTRL;
      start_hi <= `CBL_RST_START_HI;
      start_lo <= `CBL_RST_START_LO;
      width    <= `CBL_RST_WIDTH;
      blc_cfg  <= `CBL_RST_BLC;
      outfmt   <= `CBL_RST_OUTFMT;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        `CBL_ADDR_PIN_CTRL: pin_ctrl <= wdata_i;
        `CBL_ADDR_START_HI: start_hi <= {3'h0, wdata_i[4:0]};
        `CBL_ADDR_START_LO: start_lo <= wdata_i;
        `CBL_ADDR_WIDTH:    width    <= wdata_i;
        `CBL_ADDR_BLC:      blc_cfg  <= wdata_i;
        `CBL_ADDR_OUTFMT:   outfmt   <= wdata_i;
        default:            ;
      endcase
    end
  end

  // Read data, one cycle after strobe
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rd_i ? reg_read(addr_i) : 8'h00;
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [2:0] pin_s;
  logic [2:0] hs_s;
  logic [2:0] xt_s;

  // Two stages plus an edge-history stage
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_s <= 3'h0;
      hs_s  <= 3'h0;
      xt_s  <= 3'h0;
    end
    else
    begin
      pin_s <= {pin_s[1:0], multi_pin_i};
      hs_s  <= {hs_s[1:0], hsync_i};
      xt_s  <= {xt_s[1:0], crystal_clk_i};
    end
  end

  logic pin_lvl;
  logic pin_rise;
  logic hs_trail;
  logic xt_rise;
  assign pin_lvl  = pin_s[1] & ~pin_ctrl[`CBL_BIT_PIN_DIS];
  assign pin_rise = pin_lvl & ~(pin_s[2] & ~pin_ctrl[`CBL_BIT_PIN_DIS]);
  assign hs_trail = hs_s[2] & ~hs_s[1];
  assign xt_rise  = xt_s[1] & ~xt_s[2];

  // ************************************************************
  // Multi-function pin routing
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sample_clock_invert_o  <= 1'b0;
      ext_hold_o             <= 1'b0;
      external_pixel_clock_o <= 1'b0;
    end
    else
    begin
      sample_clock_invert_o  <= (pin_fn == cbl_pkg::CBL_PIN_INVERT) & pin_lvl;
      ext_hold_o             <= (pin_fn == cbl_pkg::CBL_PIN_EXT_HOLD) & pin_lvl;
      external_pixel_clock_o <= (pin_fn == cbl_pkg::CBL_PIN_EXT_EXTERNAL_PIXEL_CLOCK) & pin_lvl;
    end
  end

  // ************************************************************
  // Crystal clock output
  // ************************************************************
  logic xt_half;

  // Divide by two on crystal rising edges
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      xt_half <= 1'b0;
    else if (xt_rise)
      xt_half <= ~xt_half;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      crystal_clock_output_o <= 1'b0;
    else if (pin_ctrl[`CBL_BIT_XTAL_OFF])
      crystal_clock_output_o <= 1'b0;
    else
      crystal_clock_output_o <= pin_ctrl[`CBL_BIT_XTAL_HALF] ? xt_half : xt_s[1];
  end

  // ************************************************************
  // Internal clamp timing
  // ************************************************************
  logic [12:0] px_cnt;
  logic        px_run;
  logic [7:0]  rst_cnt;
  logic [7:0]  avg_cnt;
  logic        int_clamp;
  logic        int_mode;
  logic        blc_on;
  logic [7:0]  avg_len;

  assign int_mode  = (pin_fn != cbl_pkg::CBL_PIN_EXT_CLAMP);
  assign int_clamp = int_mode & px_run & (px_cnt == start_px);
  assign blc_on    = ~blc_cfg[`CBL_BIT_BLC_DIS];
  assign avg_len   = 8'(1 << (`CBL_PX_BASE - 1 + blc_cfg[3:2]));

  // Pixel counter from sync trailing edge
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      px_cnt <= 13'h0000;
      px_run <= 1'b0;
    end
    else if (hs_trail)
    begin
      px_cnt <= 13'h0000;
      px_run <= 1'b1;
    end
    else if (px_run)
    begin
      px_cnt <= px_cnt + 13'h0001;
      px_run <= (px_cnt != start_px);
    end
  end

  logic clamp_evt;
  assign clamp_evt = int_clamp | (~int_mode & pin_rise);

  // Restore pulse width counter
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_cnt <= 8'h00;
    else if (clamp_evt & restore_en_i & (width >= `CBL_MIN_WIDTH))
      rst_cnt <= width;
    else if (rst_cnt != 8'h00)
      rst_cnt <= rst_cnt - 8'h01;
  end

  // Averaging window, independent of clamp width
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      avg_cnt <= 8'h00;
    else if (clamp_evt & blc_on)
      avg_cnt <= avg_len;
    else if (avg_cnt != 8'h00)
      avg_cnt <= avg_cnt - 8'h01;
  end

  // ************************************************************
  // Gain hold timer when no internal clamp
  // ************************************************************
  logic [31:0] hold_cnt;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      gain_pending <= 1'b0;
      hold_cnt     <= 32'h0;
    end
    else if (clamp_evt | (hold_cnt == HOLD_CYC - 1))
    begin
      gain_pending <= wr_i;
      hold_cnt     <= 32'h0;
    end
    else
    begin
      if (wr_i)
        gain_pending <= 1'b1;
      if (gain_pending)
        hold_cnt <= hold_cnt + 32'h1;
    end
  end

  // Clamp outputs and config views
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clamp_evt_o                <= '0;
      restore_pulse_o            <= 1'b0;
      average_window_o           <= 1'b0;
      auto_black_level_comp_en_o <= 1'b0;
      average_pixels_o           <= 8'h00;
      time_constant_lines_o      <= 13'h0000;
    end
    else
    begin
      clamp_evt_o.restore        <= clamp_evt & restore_en_i;
      clamp_evt_o.average_start  <= clamp_evt & blc_on;
      clamp_evt_o.offset_load    <= clamp_evt;
      clamp_evt_o.gain_load      <= clamp_evt | (gain_pending & (hold_cnt == HOLD_CYC - 1));
      restore_pulse_o            <= (rst_cnt != 8'h00);
      average_window_o           <= (avg_cnt != 8'h00);
      auto_black_level_comp_en_o <= blc_on;
      average_pixels_o           <= avg_len;
      time_constant_lines_o      <= 13'(1 << (`CBL_TC_BASE + blc_cfg[6:4]));
    end
  end

  // ************************************************************
  // Output bus width
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      primary_bus_o   <= '0;
      secondary_bus_o <= '0;
    end
    else
    begin
      primary_bus_o   <= pix_primary_i;
      secondary_bus_o <= outfmt[`CBL_BIT_BUS48] ? pix_secondary_i : '0;
    end
  end

endmodule : cbl_top

// File: tb/cbl_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Clamp, averaging and bus checks
// ****************************************
module cbl_monitor #(
  parameter int unsigned HOLD_CYC = 20
) (
  input wire logic                    core_clk_i,
  input wire logic                    rstn_i,
  input wire cbl_pkg::cbl_pixel_t     pix_primary_i,
  input wire cbl_pkg::cbl_clamp_evt_t clamp_evt_o,
  input wire logic                    restore_pulse_o,
  input wire logic                    average_window_o,
  input wire logic [7:0]              average_pixels_o,
  input wire logic [12:0]             time_constant_lines_o,
  input wire cbl_pkg::cbl_pixel_t     primary_bus_o
);
  int unsigned rcnt;
  int unsigned wcnt;
  logic [1:0]  live;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Restore pulse length
  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i) rcnt <= 0; else rcnt <= restore_pulse_o ? rcnt + 1 : 0;
  // Averaging window length
  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i) wcnt <= 0; else wcnt <= average_window_o ? wcnt + 1 : 0;
  // Outputs settled two edges after reset
  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i) live <= 2'b00; else live <= {live[0], 1'b1};
  a_offset_always: assert property (
    clamp_evt_o.restore || clamp_evt_o.average_start |-> clamp_evt_o.offset_load) else $error("clamp without load");
  a_evt_single: assert property (
    clamp_evt_o.offset_load |=> !clamp_evt_o.offset_load [*2]) else $error("clamp event too long");
  a_restore_follow: assert property (
    $rose(restore_pulse_o) |-> $past(clamp_evt_o.restore)) else $error("restore without clamp");
  a_restore_width: assert property (
    $fell(restore_pulse_o) |-> rcnt >= 2) else $error("restore pulse too short");
  a_window_len: assert property (
    $fell(average_window_o) |-> wcnt == average_pixels_o) else $error("window length wrong");
  a_pixel_code: assert property (
    live[1] |-> average_pixels_o inside {8'h10, 8'h20, 8'h40, 8'h80}) else $error("pixel count bad");
  a_tc_power: assert property (
    live[1] |-> $onehot(time_constant_lines_o) && time_constant_lines_o >= 13'h0020) else $error("tc bad");
  a_primary_pass: assert property (
    live[1] |-> primary_bus_o == $past(pix_primary_i)) else $error("primary bus wrong");
endmodule : cbl_monitor

bind cbl_top cbl_monitor #(.HOLD_CYC(HOLD_CYC)) i_mon (.*);

// File: tb/cbl_sync_src.sv
`timescale 1ns/1ps
// ****************************************
// Video sync and crystal source
// ****************************************
module cbl_sync_src #(
  parameter int LINE = 300
) (
  input  wire logic core_clk_i,
  input  wire logic run_i,
  input  wire logic ext_clamp_i,
  input  wire logic pin_lvl_i,
  output logic      hsync_o,
  output logic      crystal_clk_o,
  output logic      multi_pin_o
);
  int pos = 0;
  // Free crystal, phase unrelated to core clock
  initial
  begin
    hsync_o = 1'b0;
    multi_pin_o = 1'b0;
    crystal_clk_o = 1'b0;
    #7;
    forever #200 crystal_clk_o = ~crystal_clk_o;
  end
  // Line position, restarts with each run
  always @(posedge core_clk_i)
    pos <= run_i ? (pos + 1) % LINE : 0;
  // Sync high at line start, clamp pulse mid line
  always @(posedge core_clk_i)
  begin
    hsync_o <= run_i && pos < 20;
    multi_pin_o <= ext_clamp_i ? (run_i && pos >= 100 && pos < 110) : pin_lvl_i;
  end
endmodule : cbl_sync_src

// File: tb/tb.sv
`timescale 1ns/1ps
// ****************************************
// Register and clamp tests
// ****************************************
module tb;
  localparam int LINE = 300;
  logic core_clk_i, rstn_i, wr_i, rd_i, multi_pin_i, hsync_i, crystal_clk_i, restore_en_i, run, ext, lvl;
  logic [7:0] addr_i, wdata_i, rdata_o, average_pixels_o, d;
  logic sample_clock_invert_o, ext_hold_o, external_pixel_clock_o, crystal_clock_output_o;
  logic restore_pulse_o, average_window_o, auto_black_level_comp_en_o;
  logic [12:0] time_constant_lines_o;
  cbl_pkg::cbl_pixel_t pix_primary_i, pix_secondary_i, primary_bus_o, secondary_bus_o;
  cbl_pkg::cbl_clamp_evt_t clamp_evt_o;
  int fail_count, samples_checked, cyc, t0, lat, la, n_off, n_avs, n_rp, n_aw, n_xr, n_gl;
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h40, 8'h00, 8'h00};
  logic [2:0] pe [4] = '{3'b100, 3'b000, 3'b010, 3'b001};
  int xe [3] = '{100, 50, 0};

  cbl_top #(.HOLD_CYC(20)) i_dut (.*);
  cbl_sync_src #(.LINE(LINE)) i_src (.core_clk_i(core_clk_i), .run_i(run), .ext_clamp_i(ext),
    .pin_lvl_i(lvl), .hsync_o(hsync_i), .crystal_clk_o(crystal_clk_i), .multi_pin_o(multi_pin_i));

  // Core clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // Event tallies and clamp latency
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if ($fell(hsync_i))
      t0 <= cyc;
    if (clamp_evt_o.offset_load)
      lat <= cyc - t0;
    n_off <= n_off + int'(clamp_evt_o.offset_load);
    n_avs <= n_avs + int'(clamp_evt_o.average_start);
    n_rp <= n_rp + int'(restore_pulse_o);
    n_aw <= n_aw + int'(average_window_o);
    n_xr <= n_xr + int'($rose(crystal_clock_output_o));
    n_gl <= n_gl + int'(clamp_evt_o.gain_load);
  end
  task automatic chk(input logic [159:0] got, input logic [159:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic tally(input int n);
    @(negedge core_clk_i);
    {n_off, n_avs, n_rp, n_aw, n_xr, n_gl} = '0;
    repeat (n) @(posedge core_clk_i);
  endtask : tally
  task automatic clamp(input logic [7:0] hi, lo, w, blc, input logic re, ex);
    wr(8'h14, hi);
    wr(8'h15, lo);
    wr(8'h16, w);
    wr(8'h17, blc);
    wr(8'h13, {3'b000, ex, 4'h0});
    restore_en_i <= re;
    ext <= ex;
    run <= 1'b1;
    tally(3 * LINE - 50);
    run <= 1'b0;
  endtask : clamp
  task automatic report_and_stop();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {rstn_i, wr_i, rd_i, restore_en_i, run, ext, lvl, addr_i, wdata_i} = '0;
    pix_primary_i = 24'h123456;
    pix_secondary_i = 24'habcdef;
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rd(i < 6 ? 8'(8'h13 + i) : 8'h20, d);
      chk(d, rv[i]);
    end
    wr(8'h14, 8'hff);
    rd(8'h14, d);
    chk(d, 8'h1f);
    lvl <= 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      wr(8'h13, {2'b00, r[1:0], r[2], 3'b000});
      repeat (6) @(posedge core_clk_i);
      chk({sample_clock_invert_o, ext_hold_o, external_pixel_clock_o}, r[2] ? 3'b000 : pe[r[1:0]]);
    end
    lvl <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h13, 8'(k << 6));
      tally(1000);
      chk(n_xr >= xe[k] - 1 && n_xr <= xe[k] + 1, 1);
    end
    for (int f = 0; f < 8; f++)
    begin
      wr(8'h17, {1'b0, 3'(f), 2'(f), 2'b00});
      repeat (2) @(posedge core_clk_i);
      chk(time_constant_lines_o, 24'(32 << f));
      chk(average_pixels_o, 24'(16 << f[1:0]));
    end
    clamp(8'h00, 8'h10, 8'h10, 8'h40, 1'b1, 1'b0);
    la = lat;
    chk({n_off, n_avs, n_rp, n_aw, auto_black_level_comp_en_o}, {32'd3, 32'd3, 32'd48, 32'd48, 1'b1});
    clamp(8'h00, 8'h30, 8'h02, 8'h4c, 1'b1, 1'b0);
    chk({n_off, n_rp, n_aw, lat}, {32'd3, 32'd6, 32'd384, la + 32'd32});
    clamp(8'h00, 8'h10, 8'h01, 8'h41, 1'b1, 1'b0);
    chk({n_off, n_avs, n_rp, n_aw, auto_black_level_comp_en_o}, {32'd3, 32'd0, 32'd0, 32'd0, 1'b0});
    clamp(8'h00, 8'h10, 8'h10, 8'h40, 1'b0, 1'b0);
    chk({n_off, n_rp}, {32'd3, 32'd0});
    clamp(8'h10, 8'h00, 8'h10, 8'h40, 1'b1, 1'b0);
    chk(n_off, 0);
    clamp(8'h1f, 8'hff, 8'h10, 8'h40, 1'b1, 1'b1);
    chk(n_off, 3);
    wr(8'h18, 8'h01);
    tally(40);
    chk(n_gl, 1);
    chk(secondary_bus_o, pix_secondary_i);
    wr(8'h18, 8'h00);
    repeat (3) @(posedge core_clk_i);
    chk({secondary_bus_o, primary_bus_o}, {24'h0, pix_primary_i});
    report_and_stop();
  end
endmodule : tb
